/* pcg_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] unit_clk_en,
  output logic [4:0][15:0] unit_ticks_ff
);
  // ------------------------------------------------------------
  // each unit advances only while its clock is enabled
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      unit_ticks_ff <= '0;
    else
      for (int u = 0; u < 5; u++)
        if (unit_clk_en[u])
          unit_ticks_ff[u] <= unit_ticks_ff[u] + 16'h0001;
  end
endmodule : pcg_periph_model
`default_nettype wire

/* pcg_pkg.sv */
`default_nettype none
package pcg_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int UNIT_N = 5;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_RUN0 = 12'h100;
  localparam logic [11:0] OFF_RUN1 = 12'h104;
  localparam logic [11:0] OFF_SLEEP0 = 12'h110;
  localparam logic [11:0] OFF_SLEEP1 = 12'h114;
  localparam logic [11:0] OFF_DEEP0 = 12'h120;
  localparam logic [11:0] OFF_DEEP1 = 12'h124;

  // ------------------------------------------------------------
  // reset values and writable fields
  // ------------------------------------------------------------
  localparam logic [31:0] RST_GATE0 = 32'h0000_0040;
  localparam logic [31:0] RST_GATE1 = 32'h0000_0000;
  localparam logic [31:0] MASK_GATE0 = 32'h0000_0048;
  localparam logic [31:0] MASK_GATE1 = 32'h0308_0000;

  // ------------------------------------------------------------
  // field positions and unit numbering
  // ------------------------------------------------------------
  localparam int BIT_HIB = 6;
  localparam int BIT_WDT = 3;
  localparam int BIT_COMPARATOR_ZERO_CLOCK_GATE = 24;
  localparam int BIT_COMPARATOR_ONE_CLOCK_GATE = 25;
  localparam int BIT_GP_TIMER_THREE_CLOCK_GATE = 19;
  localparam int U_HIB = 0;
  localparam int U_WDT = 1;
  localparam int U_COMPARATOR_ZERO_CLOCK_GATE = 2;
  localparam int U_COMPARATOR_ONE_CLOCK_GATE = 3;
  localparam int U_GP_TIMER_THREE_CLOCK_GATE = 4;
  localparam int UNIT_BIT [UNIT_N] = '{BIT_HIB, BIT_WDT, BIT_COMPARATOR_ZERO_CLOCK_GATE, BIT_COMPARATOR_ONE_CLOCK_GATE, BIT_GP_TIMER_THREE_CLOCK_GATE};
  // units whose bit sits in the second register of a set
  localparam logic [4:0] UNIT_IN_SET1 = 5'h1C;

  // ------------------------------------------------------------
  // bus answers and power modes
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PM_RUN = 3'h1,
    PM_SLEEP = 3'h2,
    PM_DEEP = 3'h4
  } pcg_pm_type;

endpackage : pcg_pkg
`default_nettype wire

/* pcg_top.sv */
// Contract
// - gating bit one clocks unit, zero stops it
// - access to unclocked unit answers bus fault
// - run, sleep, deep-sleep sets chosen by state
// - sleep sets apply only with auto gating
// - gating bits reset to zero unless noted; the code also resets run and sleep set0 to 0x40
// - deep-sleep set0 bit 6 gates hibernation
// - deep-sleep set0 bit 3 gates watchdog
// - run set1 bits 25, 24 gate comparators
// - run set1 bit 19 gates timer three
// - reserved bits read zero, writes ignored
// - deep-sleep set0 resets to 0x40
// - run set1 resets to all zeros
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pcg_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic auto_sleep_gating_enable,
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  input wire logic periph_access,
  input wire logic [4:0] periph_unit_sel,
  output logic periph_access_grant,
  output logic periph_bus_fault,
  output logic hibernate_clock_gate,
  output logic watchdog_clock_gate,
  output logic comparator_zero_clock_gate,
  output logic comparator_one_clock_gate,
  output logic gp_timer_three_clock_gate
);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction : reg_hit

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] keep);
    merge_word = ((old & ~lane_mask(be)) | (wd & lane_mask(be))) & keep;
  endfunction : merge_word

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [1:0] resp_ff;
  logic [31:0] run0_ff;
  logic [31:0] sleep0_ff;
  logic [31:0] deep0_ff;
  logic [31:0] run1_ff;
  logic [31:0] sleep1_ff;
  logic [31:0] deep1_ff;
  pcg_pkg::pcg_pm_type pm_ff;
  pcg_pkg::pcg_pm_type nxt_pm;
  logic [4:0] en_ff;
  wire [4:0] nxt_en;

  // ------------------------------------------------------------
  // bus slave: one wait cycle per access
  // ------------------------------------------------------------
  wire bus_req = avs_read | avs_write;
  wire nxt_ack = bus_req & ~ack_ff;
  wire wr_take = avs_write & ack_ff;
  wire sel_run0 = reg_hit(avs_address, pcg_pkg::OFF_RUN0);
  wire sel_run1 = reg_hit(avs_address, pcg_pkg::OFF_RUN1);
  wire sel_sleep0 = reg_hit(avs_address, pcg_pkg::OFF_SLEEP0);
  wire sel_sleep1 = reg_hit(avs_address, pcg_pkg::OFF_SLEEP1);
  wire sel_deep0 = reg_hit(avs_address, pcg_pkg::OFF_DEEP0);
  wire sel_deep1 = reg_hit(avs_address, pcg_pkg::OFF_DEEP1);
  wire mapped = sel_run0 | sel_run1 | sel_sleep0 | sel_sleep1 | sel_deep0 | sel_deep1;

  // reserved bits are never stored, so they read zero
  wire [31:0] rd_mux = ({32{sel_run0}} & run0_ff)
                     | ({32{sel_run1}} & run1_ff)
                     | ({32{sel_sleep0}} & sleep0_ff)
                     | ({32{sel_sleep1}} & sleep1_ff)
                     | ({32{sel_deep0}} & deep0_ff)
                     | ({32{sel_deep1}} & deep1_ff);
  wire [31:0] nxt_rdata = avs_read ? rd_mux : 32'h0000_0000;
  wire [1:0] nxt_resp = mapped ? pcg_pkg::RESP_OK : pcg_pkg::RESP_SLVERR;

  assign avs_waitrequest = bus_req & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign avs_response = resp_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      resp_ff <= pcg_pkg::RESP_OK;
    end
    else
    begin
      ack_ff <= nxt_ack;
      if (nxt_ack)
      begin
        rdata_ff <= nxt_rdata;
        resp_ff <= nxt_resp;
      end
    end
  end

  // ------------------------------------------------------------
  // gating registers
  // ------------------------------------------------------------
  // set0 holds hibernation and watchdog
  wire [31:0] nxt_run0 = merge_word(run0_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE0);
  wire [31:0] nxt_sleep0 = merge_word(sleep0_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE0);
  wire [31:0] nxt_deep0 = merge_word(deep0_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE0);
  // set1 holds comparators and timer three
  wire [31:0] nxt_run1 = merge_word(run1_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE1);
  wire [31:0] nxt_sleep1 = merge_word(sleep1_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE1);
  wire [31:0] nxt_deep1 = merge_word(deep1_ff, avs_writedata, avs_byteenable, pcg_pkg::MASK_GATE1);

  // reset values: set0 0x40, set1 zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run0_ff <= pcg_pkg::RST_GATE0;
      sleep0_ff <= pcg_pkg::RST_GATE0;
      deep0_ff <= pcg_pkg::RST_GATE0;
      run1_ff <= pcg_pkg::RST_GATE1;
      sleep1_ff <= pcg_pkg::RST_GATE1;
      deep1_ff <= pcg_pkg::RST_GATE1;
    end
    else if (wr_take)
    begin
      if (sel_run0)
        run0_ff <= nxt_run0;
      if (sel_sleep0)
        sleep0_ff <= nxt_sleep0;
      if (sel_deep0)
        deep0_ff <= nxt_deep0;
      if (sel_run1)
        run1_ff <= nxt_run1;
      if (sel_sleep1)
        sleep1_ff <= nxt_sleep1;
      if (sel_deep1)
        deep1_ff <= nxt_deep1;
    end
  end

  // ------------------------------------------------------------
  // power mode and set selection
  // ------------------------------------------------------------
  // without auto gating the run set stays in force
  wire go_deep = auto_sleep_gating_enable & deep_sleep_mode;
  wire go_sleep = auto_sleep_gating_enable & sleep_mode & ~deep_sleep_mode;
  assign nxt_pm = go_deep ? pcg_pkg::PM_DEEP : (go_sleep ? pcg_pkg::PM_SLEEP : pcg_pkg::PM_RUN);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pm_ff <= pcg_pkg::PM_RUN;
    else
      pm_ff <= nxt_pm;
  end

  // active set follows the power mode
  wire use_sleep = (pm_ff == pcg_pkg::PM_SLEEP);
  wire use_deep = (pm_ff == pcg_pkg::PM_DEEP);
  wire [31:0] act0 = use_deep ? deep0_ff : (use_sleep ? sleep0_ff : run0_ff);
  wire [31:0] act1 = use_deep ? deep1_ff : (use_sleep ? sleep1_ff : run1_ff);

  genvar gi;
  generate
    for (gi = 0; gi < pcg_pkg::UNIT_N; gi++)
    begin : g_unit
      // one enable per unit from its bit in the active set
      assign nxt_en[gi] = pcg_pkg::UNIT_IN_SET1[gi] ? act1[pcg_pkg::UNIT_BIT[gi]]
                                                     : act0[pcg_pkg::UNIT_BIT[gi]];
    end
  endgenerate

  // enables leave a flip-flop only, so gate cells see clean edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_ff <= 5'h00;
    else
      en_ff <= nxt_en;
  end

  assign hibernate_clock_gate = en_ff[pcg_pkg::U_HIB];
  assign watchdog_clock_gate = en_ff[pcg_pkg::U_WDT];
  assign comparator_zero_clock_gate = en_ff[pcg_pkg::U_COMPARATOR_ZERO_CLOCK_GATE];
  assign comparator_one_clock_gate = en_ff[pcg_pkg::U_COMPARATOR_ONE_CLOCK_GATE];
  assign gp_timer_three_clock_gate = en_ff[pcg_pkg::U_GP_TIMER_THREE_CLOCK_GATE];

  // ------------------------------------------------------------
  // peripheral access check
  // ------------------------------------------------------------
  wire [4:0] sel_off = periph_unit_sel & ~en_ff;
  wire [4:0] sel_on = periph_unit_sel & en_ff;
  // gated unit: fault instead of completion
  assign periph_bus_fault = periph_access & (|sel_off);
  // faulted access never reaches the unit
  assign periph_access_grant = periph_access & (|sel_on) & ~(|sel_off);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_run_set_drives:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_RUN) |=> (comparator_one_clock_gate == $past(run1_ff[pcg_pkg::BIT_COMPARATOR_ONE_CLOCK_GATE])))
    else $error("run set does not drive comparator one enable");

  a_gated_faults:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periph_access && ((periph_unit_sel & ~en_ff) != 5'h00)) |-> (periph_bus_fault && !periph_access_grant))
    else $error("access to gated unit not faulted");

  a_deep_set_used:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_DEEP) |=> (watchdog_clock_gate == $past(deep0_ff[pcg_pkg::BIT_WDT])))
    else $error("deep-sleep set not applied");

  a_no_auto_run:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!auto_sleep_gating_enable) |=> (pm_ff == pcg_pkg::PM_RUN))
    else $error("sleep set used without auto gating");

  a_reset_gated_off:
  assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (en_ff == 5'h00 && run0_ff == pcg_pkg::RST_GATE0 && sleep1_ff == 32'h0000_0000))
    else $error("gating state wrong after reset");

  a_hib_bit_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_take && sel_deep0 && avs_byteenable[0]) |=> (deep0_ff[pcg_pkg::BIT_HIB] == $past(avs_writedata[6])))
    else $error("hibernation bit not written");

  a_wdt_gated_fault:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periph_access && periph_unit_sel == 5'h02 && !watchdog_clock_gate) |-> periph_bus_fault)
    else $error("watchdog access while gated not faulted");

  a_run1_fields:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_take && sel_run1 && avs_byteenable == 4'hF) |=> (run1_ff == ($past(avs_writedata) & 32'h0308_0000)))
    else $error("run set1 fields wrong after write");

  a_gp_timer_three_clock_gate_enable:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_RUN && run1_ff[pcg_pkg::BIT_GP_TIMER_THREE_CLOCK_GATE]) ##1 (pm_ff == pcg_pkg::PM_RUN)
      |-> gp_timer_three_clock_gate)
    else $error("timer three enable not raised");

  a_reserved_zero:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((run1_ff & ~pcg_pkg::MASK_GATE1) == 32'h0000_0000) && ((deep0_ff & ~pcg_pkg::MASK_GATE0) == 32'h0000_0000))
    else $error("reserved bit set");

  a_reset_values:
  assert property (@(posedge ref_clk)
    $rose(rst_n) |-> (deep0_ff == 32'h0000_0040 && run1_ff == 32'h0000_0000))
    else $error("register reset value wrong");

  a_bus_answer:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !ack_ff && sel_run1) |=> (!avs_waitrequest && avs_readdata == $past(run1_ff)))
    else $error("read not answered in one wait cycle");

  a_fault_no_grant:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    periph_bus_fault |-> !periph_access_grant)
    else $error("faulted access granted");

  a_unmapped_error:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_read && !ack_ff && !mapped) |=> (avs_response == pcg_pkg::RESP_SLVERR && avs_readdata == 32'h0000_0000))
    else $error("unmapped read not answered with error");

  a_sleep_set_used:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_SLEEP) |=> (hibernate_clock_gate == $past(sleep0_ff[pcg_pkg::BIT_HIB])))
    else $error("sleep set not applied");

  a_deep_set1_used:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_DEEP) |=> (gp_timer_three_clock_gate == $past(deep1_ff[pcg_pkg::BIT_GP_TIMER_THREE_CLOCK_GATE])))
    else $error("deep-sleep set1 not applied");

  a_auto_deep_mode:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (auto_sleep_gating_enable && deep_sleep_mode) |=> (pm_ff == pcg_pkg::PM_DEEP))
    else $error("deep-sleep mode not entered");

  a_auto_sleep_mode:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (auto_sleep_gating_enable && sleep_mode && !deep_sleep_mode) |=> (pm_ff == pcg_pkg::PM_SLEEP))
    else $error("sleep mode not entered");

  a_wdt_bit_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_take && sel_deep0 && avs_byteenable[0]) |=> (deep0_ff[pcg_pkg::BIT_WDT] == $past(avs_writedata[3])))
    else $error("watchdog bit not written");

  a_comparator_zero_clock_gate_enable:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pm_ff == pcg_pkg::PM_RUN) |=> (comparator_zero_clock_gate == $past(run1_ff[pcg_pkg::BIT_COMPARATOR_ZERO_CLOCK_GATE])))
    else $error("run set does not drive comparator zero enable");

  a_comparator_one_clock_gate_bit_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_take && sel_run1 && avs_byteenable[3]) |=> (run1_ff[pcg_pkg::BIT_COMPARATOR_ONE_CLOCK_GATE] == $past(avs_writedata[25])))
    else $error("comparator one bit not written");

  a_grant_when_clocked:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (periph_access && periph_unit_sel == 5'h10 && gp_timer_three_clock_gate) |-> periph_access_grant)
    else $error("access to clocked unit not granted");

  a_reserved_other:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((sleep0_ff & ~pcg_pkg::MASK_GATE0) == 32'h0000_0000) && ((deep1_ff & ~pcg_pkg::MASK_GATE1) == 32'h0000_0000))
    else $error("reserved bit set in sleep or deep set");

  a_unmapped_write:
  assert property (@(posedge ref_clk) disable iff (!rst_n)
    (avs_write && !ack_ff && !mapped) |=> (avs_response == pcg_pkg::RESP_SLVERR && !avs_waitrequest))
    else $error("unmapped write not answered with error");

endmodule : pcg_top
`default_nettype wire

/* peripheral_clock_gating_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module peripheral_clock_gating_bench;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, auto_en, sleep_mode, deep_sleep_mode;
  logic periph_access, grant, fault;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [1:0] avs_response, r;
  logic [4:0] sel;
  wire [4:0] en_v;
  logic [4:0][15:0] ticks, snap;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [11:0] OFFS [6] = '{12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124};
  localparam logic [31:0] PATS [6] = '{32'h08, 32'h0200_0000, 32'h40, 32'h0100_0000, 32'h48, 32'h0008_0000};
  localparam logic [2:0] MODES [7] = '{3'h0, 3'h2, 3'h1, 3'h6, 3'h5, 3'h7, 3'h4};
  localparam logic [4:0] EXP_EN [7] = '{5'h0A, 5'h0A, 5'h0A, 5'h05, 5'h13, 5'h13, 5'h0A};

  pcg_top u_pcg_top (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .auto_sleep_gating_enable(auto_en), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .periph_access(periph_access), .periph_unit_sel(sel), .periph_access_grant(grant),
    .periph_bus_fault(fault), .hibernate_clock_gate(en_v[0]), .watchdog_clock_gate(en_v[1]),
    .comparator_zero_clock_gate(en_v[2]), .comparator_one_clock_gate(en_v[3]),
    .gp_timer_three_clock_gate(en_v[4]));

  pcg_periph_model u_pcg_periph_model (.ref_clk(ref_clk), .rst_n(rst_n), .unit_clk_en(en_v),
    .unit_ticks_ff(ticks));

  // ------------------------------------------------------------
  // clock, checks and bus access
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    chk("waitrequest", 32'(avs_waitrequest), 32'h0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, avs_read, avs_write, auto_en, sleep_mode, deep_sleep_mode, periph_access} = '0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    sel = 5'h00;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("enables after reset", 32'(en_v), 32'h01);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, OFFS[i], 32'h0, 4'hF);
      chk("reset value", q, (i % 2) ? 32'h0 : 32'h40);
      chk("read response", 32'(r), 32'(pcg_pkg::RESP_OK));
      bus(1'b1, OFFS[i], 32'hFFFF_FFFF, 4'hF);
      bus(1'b0, OFFS[i], 32'h0, 4'hF);
      chk("writable bits", q, (i % 2) ? 32'h0308_0000 : 32'h48);
    end
    bus(1'b1, 12'h104, 32'h0, 4'h7);
    bus(1'b0, 12'h104, 32'h0, 4'hF);
    chk("byte lanes", q, 32'h0300_0000);
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, i ? 12'h108 : 12'h000, 32'hFFFF_FFFF, 4'hF);
      chk("unmapped write response", 32'(r), 32'(pcg_pkg::RESP_SLVERR));
      bus(1'b0, i ? 12'h108 : 12'h000, 32'h0, 4'hF);
      chk("unmapped read data", q, 32'h0);
      chk("unmapped read response", 32'(r), 32'(pcg_pkg::RESP_SLVERR));
    end
    for (int i = 0; i < 6; i++)
      bus(1'b1, OFFS[i], PATS[i], 4'hF);
    for (int m = 0; m < 7; m++)
    begin
      @(posedge ref_clk);
      {auto_en, sleep_mode, deep_sleep_mode} <= MODES[m];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("enables per mode", 32'(en_v), 32'(EXP_EN[m]));
      snap = ticks;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int u = 0; u < 5; u++)
        chk("unit ticks", 32'(ticks[u] - snap[u]), EXP_EN[m][u] ? 32'h0000_000A : 32'h0000_0000);
      for (int u = 0; u < 5; u++)
      begin
        @(posedge ref_clk);
        periph_access <= 1'b1;
        sel <= 5'(1 << u);
        @(negedge ref_clk);
        chk("bus fault", 32'(fault), 32'(!EXP_EN[m][u]));
        chk("access grant", 32'(grant), 32'(EXP_EN[m][u]));
        @(posedge ref_clk);
        periph_access <= 1'b0;
        sel <= 5'h00;
      end
      @(negedge ref_clk);
      chk("enables after faults", 32'(en_v), 32'(EXP_EN[m]));
    end
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, 12'h120, 32'h0, 4'hF);
    chk("deep set0 after second reset", q, 32'h40);
    bus(1'b0, 12'h104, 32'h0, 4'hF);
    chk("run set1 after second reset", q, 32'h0);
    @(negedge ref_clk);
    chk("enables after second reset", 32'(en_v), 32'h01);
    finish_test();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule : peripheral_clock_gating_bench
`default_nettype wire
